//--- hdl/ome_consts.vh
/*
 * Constants of the one-time-programmable memory command engine: command codes,
 * checksum polynomial, memory geometry and timing figures.
 * Assumes inclusion by the engine file only; holds definitions only.
 */
`ifndef OME_CONSTS_VH
`define OME_CONSTS_VH

`define OME_CMD_SKIP_SEL 8'hCC
`define OME_CMD_READ_PAGE 8'hC3
`define OME_CMD_READ_FIELD 8'hF0
`define OME_CMD_WRITE_MEM 8'h0F
`define OME_CMD_COMMIT 8'h5A

`define OME_CRC_POLY_REFL 8'h8C
`define OME_CRC_INIT 8'h00
`define OME_ERASED_BYTE 8'hFF

`define OME_LAST_ADDR 7'h7F
`define OME_PAGE_LAST 5'h1F
`define OME_SEG_LAST 3'h7

`define OME_CLK_MHZ 50
`define OME_RESET_US 480
`define OME_PROG_US 2500
`define OME_RESET_CYCLES (`OME_RESET_US * `OME_CLK_MHZ)
`define OME_PROG_CYCLES (`OME_PROG_US * `OME_CLK_MHZ)

`endif

//--- hdl/ome_engine.v
/*
 * Function-command engine of a single-wire one-time-programmable memory with
 * 1024 data bits, plus the byte FIFO between the slot receiver and the engine.
 * Assumes a wire front end that reports host write slots, read slots, the wire
 * low level and the programming level, all synchronous to MCLK_IN.
 */
// What this block does
// - Code CCh selects the device; next byte is a function command.
// - Function commands are ignored unless selected since the last reset.
// - Paged read is C3h then address low byte, high byte.
// - After address bytes, send checksum of command and address bytes.
// - Paged read streams to page end, then a page checksum.
// - After each page checksum continue with next page until last.
// - Field read is F0h then address low byte, high byte.
// - Field read streams to memory end, then one checksum of all bytes.
// - After the final field checksum every read slot returns one.
// - Field read cut by reset delivers no checksum.
// - Address and data bytes travel least significant bit first.
// - Program is 0Fh, address low, high, then checksum of them.
// - Program data is gathered into an 8-byte holding buffer.
// - After 8 data bytes, send their checksum.
// - Commit ANDs the holding buffer into the addressed 8-byte segment.
// - Reset aborts programming anywhere except during the programming pulse; here reset is ignored in all of ST_PROG, also before the level.
// - After programming, send programmed contents least significant bit first.
// - Device never judges checksums; it follows the host's slots.
// - Unprogrammed bits read as one; programming only clears bits.
// - Checksums use x^8 + x^5 + x^4 + 1.
// - Wire low 480 us resets; device answers with attach_response_pulse pulse.
`include "ome_consts.vh"

module ome_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_in,
	input wire srst_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] store_r [0:DEPTH-1];
	reg [AW-1:0] wptr_r;
	reg [AW-1:0] rptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready_out = (count_r != DEPTH[AW:0]);
	assign out_valid_out = (count_r != {(AW+1){1'b0}});
	assign out_data_out = store_r[rptr_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always @(posedge clk_in)
	begin
		if (srst_in)
		begin
			wptr_r <= {AW{1'b0}};
			rptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				store_r[wptr_r] <= in_data_in;
				wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_r + 1'b1;
			end
			if (pop)
				rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_r + 1'b1;
			count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // ome_fifo

module ome_engine #(
	parameter RESET_CYCLES = `OME_RESET_CYCLES,
	parameter PROG_CYCLES = `OME_PROG_CYCLES,
	parameter FIFO_DEPTH = 8
) (
	input wire MCLK_IN,
	input wire SRST_IN,
	input wire WIRE_LOW_IN,
	input wire WR_SLOT_IN,
	input wire WR_BIT_IN,
	output wire WR_READY_OUT,
	input wire RD_SLOT_IN,
	output reg RD_BIT_OUT,
	input wire PROG_LEVEL_IN,
	output reg ATTACH_RESPONSE_PULSE_OUT,
	output reg SELECTED_OUT
);
	localparam [10:0] ST_ROM = 11'h001;
	localparam [10:0] ST_CMD = 11'h002;
	localparam [10:0] ST_ADDR = 11'h004;
	localparam [10:0] ST_TXCRC = 11'h008;
	localparam [10:0] ST_RDATA = 11'h010;
	localparam [10:0] ST_WDATA = 11'h020;
	localparam [10:0] ST_ARM = 11'h040;
	localparam [10:0] ST_PROG = 11'h080;
	localparam [10:0] ST_VERIFY = 11'h100;
	localparam [10:0] ST_ONES = 11'h200;
	localparam [10:0] ST_IDLE = 11'h400;
	localparam [1:0] PH_HDR = 2'd0;
	localparam [1:0] PH_PAGE = 2'd1;
	localparam [1:0] PH_WDAT = 2'd2;

	reg [7:0] mem_r [0:127];
	reg [7:0] hold_r [0:7];
	reg [10:0] state_r;
	reg [1:0] phase_r;
	reg [7:0] cmd_r;
	reg [7:0] crc_r;
	reg [15:0] addr_r;
	reg addr_hi_r;
	reg [2:0] cnt_r;
	reg [7:0] tx_r;
	reg [2:0] tx_bit_r;
	reg [7:0] rx_r;
	reg [2:0] rx_bit_r;
	reg rx_push_r;
	reg [16:0] low_cnt_r;
	reg rst_seen_r;
	reg [16:0] prog_cnt_r;
	reg bus_reset;
	reg tx_done;
	wire fifo_valid;
	wire [7:0] fifo_data;
	wire pop;
	wire [6:0] a7;
	wire [6:0] seg;
	wire end_chunk;
	wire [7:0] next_byte;
	integer i;

	// Reflected shift of x^8 + x^5 + x^4 + 1, least significant bit first.
	function [7:0] crc8;
		input [7:0] c;
		input [7:0] d;
		integer k;
		reg [7:0] t;
		begin
			t = c;
			for (k = 0; k < 8; k = k + 1)
				t = (t >> 1) ^ (((t[0] ^ d[k]) == 1'b1) ? `OME_CRC_POLY_REFL : 8'h00);
			crc8 = t;
		end
	endfunction

	ome_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.clk_in(MCLK_IN),
		.srst_in(SRST_IN || bus_reset),
		.in_valid_in(rx_push_r),
		.in_ready_out(WR_READY_OUT),
		.in_data_in(rx_r),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop),
		.out_data_out(fifo_data)
	);

	assign pop = fifo_valid && ((state_r & (ST_ROM | ST_CMD | ST_ADDR | ST_WDATA | ST_ARM)) != 11'h000);
	assign a7 = addr_r[6:0];
	assign seg = {addr_r[6:3], 3'b000};
	assign next_byte = mem_r[a7 + 7'd1];
	assign end_chunk = (a7 == `OME_LAST_ADDR) ||
		((cmd_r == `OME_CMD_READ_PAGE) && (addr_r[4:0] == `OME_PAGE_LAST));

	always @*
	begin
		tx_done = RD_SLOT_IN && (tx_bit_r == 3'd7) &&
			((state_r & (ST_TXCRC | ST_RDATA | ST_VERIFY)) != 11'h000);
		// No bus reset is taken while the engine is in ST_PROG, before or during the programming level.
		bus_reset = rst_seen_r && !WIRE_LOW_IN && (state_r != ST_PROG);
	end

	// Wire-level reset detection and attach_response_pulse answer.
	always @(posedge MCLK_IN)
	begin
		if (SRST_IN)
		begin
			low_cnt_r <= 17'd0;
			rst_seen_r <= 1'b0;
			ATTACH_RESPONSE_PULSE_OUT <= 1'b0;
		end
		else
		begin
			ATTACH_RESPONSE_PULSE_OUT <= bus_reset;
			if (!WIRE_LOW_IN)
				low_cnt_r <= 17'd0;
			else if (low_cnt_r != RESET_CYCLES[16:0])
				low_cnt_r <= low_cnt_r + 17'd1;
			if (bus_reset || (WIRE_LOW_IN && state_r == ST_PROG))
				rst_seen_r <= 1'b0;
			else if (WIRE_LOW_IN && low_cnt_r == RESET_CYCLES[16:0] - 17'd1)
				rst_seen_r <= 1'b1;
		end
	end

	// Host write slots gathered into bytes, least significant bit first.
	always @(posedge MCLK_IN)
	begin
		if (SRST_IN || bus_reset)
		begin
			rx_r <= 8'h00;
			rx_bit_r <= 3'd0;
			rx_push_r <= 1'b0;
		end
		else
		begin
			rx_push_r <= WR_SLOT_IN && (rx_bit_r == 3'd7);
			if (WR_SLOT_IN)
			begin
				rx_r <= {WR_BIT_IN, rx_r[7:1]};
				rx_bit_r <= rx_bit_r + 3'd1;
			end
		end
	end

	// Read slots: one bit of the outgoing byte, or a released wire otherwise.
	always @(posedge MCLK_IN)
	begin
		if (SRST_IN || bus_reset)
		begin
			RD_BIT_OUT <= 1'b1;
			tx_bit_r <= 3'd0;
		end
		else if (RD_SLOT_IN)
		begin
			if ((state_r & (ST_TXCRC | ST_RDATA | ST_VERIFY)) != 11'h000)
			begin
				RD_BIT_OUT <= tx_r[tx_bit_r];
				tx_bit_r <= tx_bit_r + 3'd1;
			end
			else
				RD_BIT_OUT <= 1'b1;
		end
	end

	always @(posedge MCLK_IN)
	begin
		if (SRST_IN)
		begin
			for (i = 0; i < 128; i = i + 1)
				mem_r[i] <= `OME_ERASED_BYTE;
			for (i = 0; i < 8; i = i + 1)
				hold_r[i] <= `OME_ERASED_BYTE;
		end
		else if (state_r == ST_WDATA && pop)
			hold_r[cnt_r] <= fifo_data;
		else if (state_r == ST_PROG && !PROG_LEVEL_IN && prog_cnt_r == PROG_CYCLES[16:0])
		begin
			for (i = 0; i < 8; i = i + 1)
				mem_r[seg + i[6:0]] <= mem_r[seg + i[6:0]] & hold_r[i];
		end
	end

	always @(posedge MCLK_IN)
	begin
		if (SRST_IN || bus_reset)
		begin
			// Any read in flight is dropped here, checksum included.
			state_r <= ST_ROM;
			phase_r <= PH_HDR;
			cmd_r <= 8'h00;
			crc_r <= `OME_CRC_INIT;
			addr_r <= 16'h0000;
			addr_hi_r <= 1'b0;
			cnt_r <= 3'd0;
			tx_r <= 8'h00;
			prog_cnt_r <= 17'd0;
			SELECTED_OUT <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_ROM:
					if (pop)
					begin
						SELECTED_OUT <= (fifo_data == `OME_CMD_SKIP_SEL);
						state_r <= (fifo_data == `OME_CMD_SKIP_SEL) ? ST_CMD : ST_IDLE;
					end
				ST_CMD:
					if (pop)
					begin
						cmd_r <= fifo_data;
						crc_r <= crc8(`OME_CRC_INIT, fifo_data);
						addr_hi_r <= 1'b0;
						if (fifo_data == `OME_CMD_READ_PAGE || fifo_data == `OME_CMD_READ_FIELD ||
							fifo_data == `OME_CMD_WRITE_MEM)
							state_r <= ST_ADDR;
						else
							state_r <= ST_IDLE;
					end
				ST_ADDR:
					if (pop)
					begin
						crc_r <= crc8(crc_r, fifo_data);
						addr_hi_r <= 1'b1;
						if (!addr_hi_r)
							addr_r[7:0] <= fifo_data;
						else
						begin
							addr_r[15:8] <= fifo_data;
							tx_r <= crc8(crc_r, fifo_data);
							phase_r <= PH_HDR;
							state_r <= ST_TXCRC;
						end
					end
				ST_TXCRC:
					if (tx_done)
					begin
						// The device moves on whatever the host thought of the checksum.
						crc_r <= `OME_CRC_INIT;
						cnt_r <= 3'd0;
						if (phase_r == PH_WDAT)
							state_r <= ST_ARM;
						else if (phase_r == PH_HDR && cmd_r == `OME_CMD_WRITE_MEM)
							state_r <= ST_WDATA;
						else if (phase_r == PH_HDR)
						begin
							tx_r <= mem_r[a7];
							crc_r <= crc8(`OME_CRC_INIT, mem_r[a7]);
							state_r <= ST_RDATA;
						end
						else if (a7 == `OME_LAST_ADDR)
							state_r <= ST_ONES;
						else
						begin
							addr_r <= addr_r + 16'd1;
							tx_r <= next_byte;
							crc_r <= crc8(`OME_CRC_INIT, next_byte);
							state_r <= ST_RDATA;
						end
					end
				ST_RDATA:
					if (tx_done)
					begin
						if (end_chunk)
						begin
							tx_r <= crc_r;
							phase_r <= PH_PAGE;
							state_r <= ST_TXCRC;
						end
						else
						begin
							addr_r <= addr_r + 16'd1;
							tx_r <= next_byte;
							crc_r <= crc8(crc_r, next_byte);
						end
					end
				ST_WDATA:
					if (pop)
					begin
						crc_r <= crc8(crc_r, fifo_data);
						cnt_r <= cnt_r + 3'd1;
						if (cnt_r == `OME_SEG_LAST)
						begin
							tx_r <= crc8(crc_r, fifo_data);
							phase_r <= PH_WDAT;
							state_r <= ST_TXCRC;
						end
					end
				ST_ARM:
					if (pop)
					begin
						prog_cnt_r <= 17'd0;
						state_r <= (fifo_data == `OME_CMD_COMMIT) ? ST_PROG : ST_IDLE;
					end
				ST_PROG:
					if (PROG_LEVEL_IN)
					begin
						if (prog_cnt_r != PROG_CYCLES[16:0])
							prog_cnt_r <= prog_cnt_r + 17'd1;
					end
					else if (prog_cnt_r == 17'd0)
						// The host applies the level some cycles after the commit code.
						state_r <= ST_PROG;
					else if (prog_cnt_r == PROG_CYCLES[16:0])
					begin
						cnt_r <= 3'd0;
						tx_r <= mem_r[seg] & hold_r[0];
						state_r <= ST_VERIFY;
					end
					else
						state_r <= ST_IDLE;
				ST_VERIFY:
					if (tx_done)
					begin
						cnt_r <= cnt_r + 3'd1;
						tx_r <= mem_r[seg + {4'd0, cnt_r + 3'd1}];
						if (cnt_r == `OME_SEG_LAST)
							state_r <= ST_IDLE;
					end
				ST_ONES:
					state_r <= ST_ONES;
				ST_IDLE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // ome_engine

//--- sim/ome_engine_props.sv
/* Checker for the command engine's top-level ports.
 * Assumes one clock domain and a synchronous active-high reset. */
module ome_engine_props #(
	parameter RESET_CYCLES = 24000,
	parameter PROG_CYCLES = 125000,
	parameter FIFO_DEPTH = 8
) (
	input wire MCLK_IN,
	input wire SRST_IN,
	input wire WIRE_LOW_IN,
	input wire WR_SLOT_IN,
	input wire WR_BIT_IN,
	input wire WR_READY_OUT,
	input wire RD_SLOT_IN,
	input wire RD_BIT_OUT,
	input wire PROG_LEVEL_IN,
	input wire ATTACH_RESPONSE_PULSE_OUT,
	input wire SELECTED_OUT
);
	logic [3:0] since_wr_r;
	int low_cnt_r;
	always @(posedge MCLK_IN)
		if (SRST_IN || WR_SLOT_IN) since_wr_r <= 4'h0;
		else if (since_wr_r != 4'hF) since_wr_r <= since_wr_r + 4'h1;
	always @(posedge MCLK_IN)
		if (SRST_IN || !WIRE_LOW_IN) low_cnt_r <= 0;
		else if (low_cnt_r <= RESET_CYCLES) low_cnt_r <= low_cnt_r + 1;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (SRST_IN);
	sequence long_low_end;
		WIRE_LOW_IN && low_cnt_r >= RESET_CYCLES ##1 !WIRE_LOW_IN;
	endsequence
	a_reset_idle_state: assert property (disable iff (1'b0) SRST_IN |=> !SELECTED_OUT
		&& RD_BIT_OUT && !ATTACH_RESPONSE_PULSE_OUT && WR_READY_OUT)
		else $error("outputs not idle after reset");
	a_attach_response_pulse_single: assert property (ATTACH_RESPONSE_PULSE_OUT |=>
		!ATTACH_RESPONSE_PULSE_OUT) else $error("attach_response_pulse pulse too long");
	a_attach_response_pulse_follows_reset: assert property (long_low_end |->
		##[1:3] ATTACH_RESPONSE_PULSE_OUT) else $error("no attach_response_pulse after bus reset");
	a_attach_response_pulse_unselects: assert property (ATTACH_RESPONSE_PULSE_OUT |->
		!SELECTED_OUT) else $error("still selected at attach_response_pulse");
	a_select_after_byte: assert property ($rose(SELECTED_OUT) |->
		since_wr_r < 4'h6) else $error("selection without a received byte");
	a_select_held: assert property ($fell(SELECTED_OUT) |-> $past(WIRE_LOW_IN)
		|| $past(WIRE_LOW_IN, 2) || $past(WIRE_LOW_IN, 3)) else $error("selection lost");
	a_unselected_ones: assert property (!SELECTED_OUT && RD_SLOT_IN |=>
		RD_BIT_OUT) else $error("unselected device returned zero");
	a_zero_needs_slot: assert property ($fell(RD_BIT_OUT) |->
		$past(RD_SLOT_IN)) else $error("read bit changed without a slot");
endmodule // ome_engine_props

bind ome_engine ome_engine_props #(.RESET_CYCLES(RESET_CYCLES), .PROG_CYCLES(PROG_CYCLES),
	.FIFO_DEPTH(FIFO_DEPTH)) u_props (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
	.WIRE_LOW_IN(WIRE_LOW_IN), .WR_SLOT_IN(WR_SLOT_IN), .WR_BIT_IN(WR_BIT_IN),
	.WR_READY_OUT(WR_READY_OUT), .RD_SLOT_IN(RD_SLOT_IN), .RD_BIT_OUT(RD_BIT_OUT),
	.PROG_LEVEL_IN(PROG_LEVEL_IN), .ATTACH_RESPONSE_PULSE_OUT(ATTACH_RESPONSE_PULSE_OUT),
	.SELECTED_OUT(SELECTED_OUT));

//--- sim/ome_engine_tb.sv
/* Self-checking bench for the command engine with a host model on its slot side.
 * Assumes shortened bus reset and programming counts. */
module ome_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC = 20;
	localparam int PC = 40;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wl, ws, wb, wr_rdy, rs, rb, pl, att, sel;
	logic [7:0] mem [0:127];
	logic [7:0] b;
	int num_errors = 0;
	int checked = 0;
	bit seen;
	always #10 clk = ~clk;
	ome_engine #(.RESET_CYCLES(RC), .PROG_CYCLES(PC)) dut (.MCLK_IN(clk), .SRST_IN(srst),
		.WIRE_LOW_IN(wl), .WR_SLOT_IN(ws), .WR_BIT_IN(wb), .WR_READY_OUT(wr_rdy),
		.RD_SLOT_IN(rs), .RD_BIT_OUT(rb), .PROG_LEVEL_IN(pl),
		.ATTACH_RESPONSE_PULSE_OUT(att), .SELECTED_OUT(sel));
	ome_host host (.clk_in(clk), .attach_in(att), .rd_bit_in(rb), .wire_low_out(wl),
		.wr_slot_out(ws), .wr_bit_out(wb), .rd_slot_out(rs), .prog_level_out(pl));
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
		return c;
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic restart(input logic [7:0] first);
		host.bus_reset(RC + 2, seen);
		check({7'h00, seen}, 8'h01);
		host.send_byte(first);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] a);
		restart(8'hCC);
		check({7'h00, sel}, 8'h01);
		host.send_byte(op);
		host.send_byte(a);
		host.send_byte(8'h00);
		host.read_byte(b);
		check(b, crc(crc(crc(8'h00, op), a), 8'h00));
	endtask
	task automatic page_read(input int start);
		logic [7:0] c;
		cmd(8'hC3, start[7:0]);
		c = 8'h00;
		for (int a = start; a < 128; a++)
		begin
			host.read_byte(b);
			check(b, mem[a]);
			c = crc(c, mem[a]);
			if (a % 32 == 31)
			begin
				host.read_byte(b);
				check(b, c);
				c = 8'h00;
			end
		end
		host.read_byte(b);
		check(b, 8'hFF);
	endtask
	task automatic field_read(input int start, input int stop);
		logic [7:0] c;
		cmd(8'hF0, start[7:0]);
		c = 8'h00;
		for (int a = start; a < stop; a++)
		begin
			host.read_byte(b);
			check(b, mem[a]);
			c = crc(c, mem[a]);
		end
		if (stop == 128)
		begin
			host.read_byte(b);
			check(b, c);
			host.read_byte(b);
			check(b, 8'hFF);
		end
	endtask
	task automatic write_seg(input int adr, input logic [7:0] seed);
		logic [7:0] c;
		logic [7:0] d;
		cmd(8'h0F, adr[7:0]);
		c = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			d = seed ^ {i[3:0], ~i[3:0]};
			host.send_byte(d);
			c = crc(c, d);
			mem[adr + i] = mem[adr + i] & d;
		end
		host.read_byte(b);
		check(b, c);
		host.send_byte(8'h5A);
		host.prog(PC + 2);
		for (int i = 0; i < 8; i++)
		begin
			host.read_byte(b);
			check(b, mem[adr + i]);
		end
	endtask
	task automatic abort_fill;
		field_read(0, 5);
		restart(8'hF0);
		host.read_byte(b);
		check(b, 8'hFF);
		for (int i = 0; i < 8; i++)
			host.send_byte(8'hC3);
		check({7'h00, wr_rdy}, 8'h00);
		restart(8'hCC);
		check({7'h00, wr_rdy}, 8'h01);
	endtask
	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'hFF;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		page_read(28);
		write_seg(8, 8'hA5);
		write_seg(8, 8'h3C);
		write_seg(120, 8'h96);
		field_read(0, 128);
		page_read(0);
		abort_fill();
		wrap_up();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
endmodule // ome_engine_tb

//--- sim/ome_host.sv
/* Bus host model driving the slot-level front-end signals of the engine.
 * Assumes the engine samples on the rising edge of clk_in. */
module ome_host (
	input wire logic clk_in,
	input wire logic attach_in,
	input wire logic rd_bit_in,
	output logic wire_low_out,
	output logic wr_slot_out,
	output logic wr_bit_out,
	output logic rd_slot_out,
	output logic prog_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wire_low_out = 1'b0;
		wr_slot_out = 1'b0;
		wr_bit_out = 1'b0;
		rd_slot_out = 1'b0;
		prog_level_out = 1'b0;
	end
	task automatic bus_reset(input int n, output bit seen);
		seen = 0;
		@(posedge clk_in) wire_low_out <= 1'b1;
		repeat (n) @(posedge clk_in);
		wire_low_out <= 1'b0;
		repeat (6)
		begin
			@(posedge clk_in);
			if (attach_in === 1'b1) seen = 1;
		end
	endtask
	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_in);
			wr_slot_out <= 1'b1;
			wr_bit_out <= v[i];
		end
		@(posedge clk_in);
		wr_slot_out <= 1'b0;
		wr_bit_out <= ~v[7];
		repeat (3) @(posedge clk_in);
	endtask
	task automatic read_byte(output logic [7:0] v);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_in) rd_slot_out <= 1'b1;
			@(posedge clk_in) rd_slot_out <= 1'b0;
			@(posedge clk_in) v[i] = rd_bit_in;
		end
	endtask
	task automatic prog(input int n);
		@(posedge clk_in) prog_level_out <= 1'b1;
		repeat (n) @(posedge clk_in);
		prog_level_out <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
endmodule // ome_host
